// >>> logic/alu_ops_regs.vh
/*
 Constants for the subtract/xor/swap datapath: operation codes,
 status flag positions, destination codes and reset values.
 Assumes inclusion by bare name from the design files.
*/
`ifndef ALU_OPS_REGS_VH
`define ALU_OPS_REGS_VH

`define OP_NONE        3'h0
`define OP_SUB_LIT     3'h1
`define OP_SUB_REG     3'h2
`define OP_XOR_LIT     3'h3
`define OP_XOR_REG     3'h4
`define OP_SWAP_REG    3'h5

`define FLAG_CARRY     0
`define FLAG_NIBBLE    1
`define FLAG_ZERO      2

`define DEST_ACC       1'h0
`define DEST_REG       1'h1

`define ACC_RESET      8'h00
`define STATUS_RESET   3'h0

`endif

// >>> logic/alu_ops_core.v
/*
 Combinational result and flag logic for five 8-bit operations.
 Assumes operands are stable for the cycle and the caller stores results.
*/
`timescale 1ns/100ps
`include "alu_ops_regs.vh"

module alu_ops_core #(
   parameter WIDTH = 8
) (
   // Operation and operands
   input  wire [2:0]       op,
   input  wire [WIDTH-1:0] acc,
   input  wire [WIDTH-1:0] operand,
   input  wire [2:0]       status_in,
   // Results
   output reg  [WIDTH-1:0] result,
   output reg  [2:0]       status_out,
   output reg              valid
);

   localparam HALF = WIDTH / 2;

   wire [WIDTH:0] diff;
   wire [HALF:0]  diff_low;

   // Extra bit is the borrow; inverted it is the carry flag
   assign diff     = {1'b0, operand} - {1'b0, acc};
   assign diff_low = {1'b0, operand[HALF-1:0]} - {1'b0, acc[HALF-1:0]};

   always @* begin
      result     = {WIDTH{1'b0}};
      status_out = status_in;
      valid      = 1'b1;
      case (op)
         `OP_SUB_LIT, `OP_SUB_REG: begin
            result = diff[WIDTH-1:0]; // RL1 RL2
            status_out[`FLAG_CARRY]  = ~diff[WIDTH]; // RL1 RL2
            status_out[`FLAG_NIBBLE] = ~diff_low[HALF]; // RL1 RL2
            status_out[`FLAG_ZERO]   = (diff[WIDTH-1:0] == {WIDTH{1'b0}}); // RL8
         end
         `OP_XOR_LIT, `OP_XOR_REG: begin
            result = acc ^ operand; // RL4 RL7
            status_out[`FLAG_ZERO] = ((acc ^ operand) == {WIDTH{1'b0}}); // RL8
         end
         `OP_SWAP_REG: begin
            // Flags pass through untouched
            result = {operand[HALF-1:0], operand[WIDTH-1:HALF]}; // RL5
         end
         default: begin
            valid = 1'b0;
         end
      endcase
   end

endmodule

// >>> logic/alu_ops_top.v
/*
 Datapath for literal/register subtract, literal/register xor and
 nibble exchange. Holds the accumulator and the three status flags,
 and returns register write-backs through a one-cycle strobe.
 Every output is a flop; results appear one edge after the op.

 Assumes the core's decoder gives one operation per cycle with the
 register operand already read, that the register file writes
 RF_WR_DATA when RF_WR_EN is high, and that ARST_N may be released
 at any time relative to MCLK.
*/
// Notes on behaviour
// [RL1] Literal subtract: literal minus acc into acc; carry, nibble, zero.
// [RL2] Register subtract: register minus acc; carry, nibble flags, zero.
// [RL3] Register subtract and xor: select 0 to acc, 1 to register.
// [RL4] Literal xor: acc xor literal into acc; only zero updates.
// [RL5] Nibble exchange swaps register halves; no flag changes.
// [RL6] Nibble exchange result: select 0 to acc, 1 to register.
// [RL7] Register xor of acc with register at address 0..127; zero only.
// [RL8] Zero flag set when result is zero; unaffected flags keep value.
`timescale 1ns/100ps
`include "alu_ops_regs.vh"

module alu_ops_top #(
   parameter WIDTH  = 8,
   parameter AWIDTH = 7
) (
   // Clock and reset
   input  wire              MCLK,
   input  wire              ARST_N,
   // Operation request
   input  wire              OP_VALID,
   input  wire [2:0]        OP_CODE,
   input  wire              DEST_SEL,
   input  wire [WIDTH-1:0]  LITERAL,
   input  wire [AWIDTH-1:0] REG_ADDR,
   input  wire [WIDTH-1:0]  REG_DATA,
   // Register file write-back
   output reg               RF_WR_EN,
   output reg  [AWIDTH-1:0] RF_WR_ADDR,
   output reg  [WIDTH-1:0]  RF_WR_DATA,
   // Accumulator and flags
   output reg  [WIDTH-1:0]  ACC,
   output reg               CARRY_FLAG,
   output reg               NIBBLE_BORROW_INVERSE_FLAG,
   output reg               ZERO_FLAG
);

   localparam NFLAGS = 3;
   localparam [NFLAGS-1:0] FLAGS_RESET = `STATUS_RESET;

   // Reset release path
   reg               rst_meta;
   reg               rst_sync;
   // Operation decode
   reg               is_reg_op;
   reg               is_sub;
   reg               is_xor;
   reg               take_op;
   reg               to_reg;
   reg  [NFLAGS-1:0] flag_update;
   reg  [WIDTH-1:0]  operand;
   // Next state
   reg  [WIDTH-1:0]  next_acc;
   reg               next_wr_en;
   reg  [AWIDTH-1:0] next_wr_addr;
   reg  [WIDTH-1:0]  next_wr_data;
   wire [NFLAGS-1:0] next_flags;
   // Core interface
   wire [WIDTH-1:0]  result;
   wire [NFLAGS-1:0] core_status;
   wire              op_known;
   wire [NFLAGS-1:0] status;

   // Reset drops at once but rises only after two edges, so every
   // flop reset by rst_sync leaves reset on the same clean edge
   always @(posedge MCLK or negedge ARST_N) begin
      if (!ARST_N) begin
         rst_meta <= 1'b0;
         rst_sync <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_sync <= rst_meta;
      end
   end

   assign status = {ZERO_FLAG, NIBBLE_BORROW_INVERSE_FLAG, CARRY_FLAG};

   // Operation class decode; unknown codes decode to nothing
   always @* begin
      is_sub    = 1'b0;
      is_xor    = 1'b0;
      is_reg_op = 1'b0;
      case (OP_CODE)
         `OP_SUB_LIT: begin
            is_sub = 1'b1; // RL1
         end
         `OP_SUB_REG: begin
            is_sub    = 1'b1; // RL2
            is_reg_op = 1'b1;
         end
         `OP_XOR_LIT: begin
            is_xor = 1'b1; // RL4
         end
         `OP_XOR_REG: begin
            is_xor    = 1'b1; // RL7
            is_reg_op = 1'b1;
         end
         `OP_SWAP_REG: begin
            // Swap only routes its result; it touches no flag
            is_reg_op = 1'b1; // RL5 RL6
         end
         default: begin
            is_reg_op = 1'b0;
         end
      endcase
   end

   // Register operations take the file operand, literal ones the literal
   always @* begin
      operand = is_reg_op ? REG_DATA : LITERAL; // RL7
      take_op = OP_VALID && op_known;
      to_reg  = is_reg_op && (DEST_SEL == `DEST_REG); // RL3 RL6
   end

   // Which flags the current operation may touch
   always @* begin
      flag_update               = {NFLAGS{1'b0}};
      flag_update[`FLAG_CARRY]  = take_op && is_sub; // RL1 RL2
      flag_update[`FLAG_NIBBLE] = take_op && is_sub; // RL1 RL2
      flag_update[`FLAG_ZERO]   = take_op && (is_sub || is_xor); // RL8
   end

   // Masked flags keep their value, whatever the core hands back
   genvar i;
   generate
      for (i = 0; i < NFLAGS; i = i + 1) begin : g_flag
         assign next_flags[i] = flag_update[i] ? core_status[i] // RL8
                                               : status[i];
      end
   endgenerate

   alu_ops_core #(
      .WIDTH      (WIDTH)
   ) u_core (
      .op         (OP_CODE),
      .acc        (ACC),
      .operand    (operand),
      .status_in  (status),
      .result     (result),
      .status_out (core_status),
      .valid      (op_known)
   );

   // Literal ops ignore the destination select and always land in acc
   always @* begin
      next_acc     = ACC;
      next_wr_en   = 1'b0;
      next_wr_addr = RF_WR_ADDR;
      next_wr_data = RF_WR_DATA;
      if (take_op) begin
         if (to_reg) begin
            next_wr_en   = 1'b1; // RL3 RL6
            next_wr_addr = REG_ADDR;
            next_wr_data = result;
         end else begin
            next_acc = result; // RL1 RL4 RL3 RL6
         end
      end
   end

   always @(posedge MCLK or negedge rst_sync) begin
      if (!rst_sync) begin
         ACC <= `ACC_RESET;
      end else begin
         ACC <= next_acc;
      end
   end

   always @(posedge MCLK or negedge rst_sync) begin
      if (!rst_sync) begin
         CARRY_FLAG <= FLAGS_RESET[`FLAG_CARRY];
      end else begin
         CARRY_FLAG <= next_flags[`FLAG_CARRY]; // RL1 RL2
      end
   end

   always @(posedge MCLK or negedge rst_sync) begin
      if (!rst_sync) begin
         NIBBLE_BORROW_INVERSE_FLAG <= FLAGS_RESET[`FLAG_NIBBLE];
      end else begin
         NIBBLE_BORROW_INVERSE_FLAG <= next_flags[`FLAG_NIBBLE]; // RL1 RL2
      end
   end

   always @(posedge MCLK or negedge rst_sync) begin
      if (!rst_sync) begin
         ZERO_FLAG <= FLAGS_RESET[`FLAG_ZERO];
      end else begin
         ZERO_FLAG <= next_flags[`FLAG_ZERO]; // RL8
      end
   end

   // Write strobe lasts one cycle; the file must take it on that edge
   always @(posedge MCLK or negedge rst_sync) begin
      if (!rst_sync) begin
         RF_WR_EN <= 1'b0;
      end else begin
         RF_WR_EN <= next_wr_en; // RL3 RL6
      end
   end

   // Address and data hold after the strobe until the next write
   always @(posedge MCLK or negedge rst_sync) begin
      if (!rst_sync) begin
         RF_WR_ADDR <= {AWIDTH{1'b0}};
         RF_WR_DATA <= {WIDTH{1'b0}};
      end else begin
         RF_WR_ADDR <= next_wr_addr;
         RF_WR_DATA <= next_wr_data;
      end
   end

endmodule

// >>> tb/alu_ops_top_sva.sv
/* Port checker for the subtract/xor/swap datapath.
   Assumes the bind below and that outputs update one edge after an op. */
`timescale 1ns/100ps
module alu_ops_chk #(parameter WIDTH = 8, AWIDTH = 7) (
   input MCLK, ARST_N, OP_VALID, DEST_SEL, RF_WR_EN, CARRY_FLAG,
   input NIBBLE_BORROW_INVERSE_FLAG, ZERO_FLAG,
   input [2:0] OP_CODE,
   input [AWIDTH-1:0] REG_ADDR, RF_WR_ADDR,
   input [WIDTH-1:0] LITERAL, REG_DATA, RF_WR_DATA, ACC);
   default clocking @(posedge MCLK); endclocking
   default disable iff (!ARST_N);
   wire [WIDTH-1:0] res = RF_WR_EN ? RF_WR_DATA : ACC;
   wire [2:0] fl = {ZERO_FLAG, NIBBLE_BORROW_INVERSE_FLAG, CARRY_FLAG};
   wire [7:0] o = OP_VALID ? 8'h01 << OP_CODE : 8'h00;
   property p_sub_lit;
      o[1] |=> ACC == $past(LITERAL - ACC) && !RF_WR_EN &&
         fl[1:0] == $past({ACC[3:0] <= LITERAL[3:0], ACC <= LITERAL});
   endproperty
   a_sub_lit: assert property (p_sub_lit) else $error("lit sub");
   property p_sub_reg;
      o[2] |=> res == $past(REG_DATA - ACC) &&
         fl[1:0] == $past({ACC[3:0] <= REG_DATA[3:0], ACC <= REG_DATA});
   endproperty
   a_sub_reg: assert property (p_sub_reg) else $error("reg sub");
   property p_dest;
      o[2] || o[4] || o[5] |=> RF_WR_EN == $past(DEST_SEL) &&
         (!RF_WR_EN || RF_WR_ADDR == $past(REG_ADDR) && $stable(ACC));
   endproperty
   a_dest: assert property (p_dest) else $error("dest");
   property p_xor_lit;
      o[3] |=> ACC == $past(ACC ^ LITERAL) && $stable(fl[1:0]) && !RF_WR_EN;
   endproperty
   a_xor_lit: assert property (p_xor_lit) else $error("lit xor");
   property p_swap;
      o[5] |=> res == {$past(REG_DATA[3:0]), $past(REG_DATA[7:4])} &&
         $stable(fl);
   endproperty
   a_swap: assert property (p_swap) else $error("swap");
   property p_swap_reg;
      o[5] && DEST_SEL |=> RF_WR_EN && $stable(ACC);
   endproperty
   a_swap_reg: assert property (p_swap_reg) else $error("swap dest");
   property p_xor_reg;
      o[4] |=> res == $past(ACC ^ REG_DATA) && $stable(fl[1:0]);
   endproperty
   a_xor_reg: assert property (p_xor_reg) else $error("reg xor");
   property p_zero;
      |o[4:1] |=> ZERO_FLAG == (res == 0);
   endproperty
   a_zero: assert property (p_zero) else $error("zero");
   property p_idle;
      !(|o[5:1]) |=> !RF_WR_EN && $stable(ACC) && $stable(fl);
   endproperty
   a_idle: assert property (p_idle) else $error("idle change");
   c_wb: cover property (o[2] && DEST_SEL);
   c_eq: cover property (o[1] && ACC == LITERAL);
   c_z: cover property ($rose(ZERO_FLAG));
endmodule
bind alu_ops_top alu_ops_chk #(.WIDTH(WIDTH), .AWIDTH(AWIDTH)) u_chk (.*);

// >>> tb/tb_alu_ops_top.sv
/* Self-checking bench: random ops against a reference model.
   Assumes one op per cycle, results visible after the taking edge. */
`timescale 1ns/100ps
module tb_alu_ops_top;
   reg MCLK = 0, ARST_N = 0, OP_VALID = 0, DEST_SEL = 0, we;
   reg [2:0] OP_CODE = 0, m_fl = 0;
   reg [6:0] REG_ADDR = 0;
   reg [7:0] LITERAL = 0, REG_DATA = 0, m_acc = 0, r;
   wire RF_WR_EN, CARRY_FLAG, NIBBLE_BORROW_INVERSE_FLAG, ZERO_FLAG;
   wire [6:0] RF_WR_ADDR;
   wire [7:0] RF_WR_DATA, ACC;
   logic [26:0] q[$], e;
   int bad_count = 0, check_count = 0;
   always #50 MCLK = ~MCLK;
   alu_ops_top u_dut (.*);
   task chk(input [26:0] s, x);
      check_count++;
      if (s !== x) begin
         bad_count++;
         $display("[ERR] %0t got %h exp %h", $time, s, x);
      end
   endtask
   task summarize;
      $display("checks %0d errors %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   always @(posedge MCLK) begin
      #2;
      if (q.size() > 0) begin
         e = q.pop_front();
         chk({RF_WR_EN, RF_WR_EN ? {RF_WR_ADDR, RF_WR_DATA} : 15'h0, ACC,
            ZERO_FLAG, NIBBLE_BORROW_INVERSE_FLAG, CARRY_FLAG},
            e);
      end
   end
   initial begin
      void'($urandom(80056));
      repeat (5) @(posedge MCLK);
      #1 ARST_N = 1;
      repeat (3) @(posedge MCLK);
      for (int i = 0; i < 3000; i++) begin
         #1 OP_VALID = $urandom % 8 != 0;
         OP_CODE = $urandom;
         DEST_SEL = $urandom;
         REG_ADDR = $urandom;
         LITERAL = $urandom % 4 ? $urandom : m_acc;
         REG_DATA = $urandom % 4 ? $urandom : m_acc;
         @(posedge MCLK);
         r = OP_CODE == 1 || OP_CODE == 3 ? LITERAL : REG_DATA;
         we = 0;
         if (OP_VALID && OP_CODE inside {[1:5]}) begin
            case (OP_CODE)
               1, 2: begin
                  m_fl[1:0] = {m_acc[3:0] <= r[3:0], m_acc <= r};
                  r = r - m_acc;
               end
               3, 4: r = r ^ m_acc;
               default: r = {r[3:0], r[7:4]};
            endcase
            if (OP_CODE != 5) m_fl[2] = r == 0;
            we = DEST_SEL && (OP_CODE == 2 || OP_CODE > 3);
            if (!we) m_acc = r;
         end
         q.push_back({we, we ? {REG_ADDR, r} : 15'h0, m_acc, m_fl});
      end
      #1 OP_VALID = 0;
      repeat (2) @(posedge MCLK);
      #5 $display("random op test done");
      summarize;
   end
   initial begin
      #500000 bad_count++;
      summarize;
   end
endmodule
